// file: hdl/dma_block_regs.vh
// Register offsets, field positions and codes of the block-transfer DMA
`ifndef DMA_BLOCK_REGS_VH
`define DMA_BLOCK_REGS_VH
// Register byte offsets
`define OFS_SRC       8'h00
`define OFS_DST       8'h04
`define OFS_SIZE      8'h08
`define OFS_BCNT      8'h0C
`define OFS_CCR       8'h10
`define OFS_BAND      8'h14
`define OFS_STAT      8'h18
// channel_control_reg fields
`define CCR_SIZE      0
`define CCR_SSTEP     1
`define CCR_SDOWN     2
`define CCR_DSTEP     3
`define CCR_DDOWN     4
`define CCR_BLOCK_ENABLE      5
`define CCR_BDIR      6
`define CCR_CHB       7
`define CCR_SEL_LO    8
`define CCR_SEL_HI    11
// band_control_reg fields
`define BAND_FAE      0
`define BAND_DTE      1
`define BAND_END_IRQ_ENABLE     2
// Status fields
`define STAT_BUSY     0
`define STAT_DONE     1
`define STAT_BAD      2
// Reset values
`define RST_ADDR      24'h000000
`define RST_BYTE      8'h00
`define RST_BCNT      16'h0000
`define RST_CCR       12'h000
// Activation source codes
`define SRC_LAST_IRQ  4'h6
`define SRC_EXT_EDGE  4'h7
`define SRC_EXT_LVL   4'h8
`define SRC_AUTO      4'h9
// Modes
`define MODE_SHORT    2'h0
`define MODE_NORMAL   2'h1
`define MODE_BLOCK    2'h2
`endif

// file: hdl/dma_block_xfer.v
// Block-transfer mode DMA channel with source selection
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
`include "dma_block_regs.vh"
// Functional notes
// - Block mode needs full-address and block enable
// - One whole block per request, N times
// - Source from A register, destination from B
// - Step by one or two, up, down, fixed
// - Separate stepping for source and destination
// - Area select picks destination or source block
// - Size counter counts down, burst until zero
// - Size counter reloads from hold at block end
// - Block area address restored at block end
// - Block count down; zero clears enable, stops
// - Expiry with end enable raises interrupt
// - Serial, timer A and external requests accepted
// - Internal, external and auto request classes
// - Sources limited by mode and channel
// - Falling edge sensing except short channel A
// - Low level sensing except short channel A
// - One block per falling edge, edges once
// - Level low repeats, bus released each block
// - Started block completes, no interruption
module dma_block_xfer
(
    // Clock and reset
    input  wire        mclk,
    input  wire        rstn,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Activation sources
    input  wire        serial0_tx_irq,
    input  wire        serial0_rx_irq,
    input  wire        serial1_tx_irq,
    input  wire        serial1_rx_irq,
    input  wire        timer0_match_irq,
    input  wire        timer1_match_irq,
    input  wire        timer2_match_irq,
    input  wire        ext_request_pin_n,
    // Memory master
    output wire        mem_req,
    output wire        mem_we,
    output wire        mem_word,
    output wire [23:0] mem_addr,
    output reg  [15:0] mem_wdata,
    input  wire [15:0] mem_rdata,
    input  wire        mem_ready,
    // Status outputs
    output wire        bus_busy,
    output wire        transfer_end_irq
);

// Sequencer states
localparam S_IDLE = 2'b00;
localparam S_RD   = 2'b01;
localparam S_WR   = 2'b10;
localparam S_END  = 2'b11;

reg  [23:0] source_address;
reg  [23:0] destination_address;
reg  [7:0]  block_size_hold;
reg  [7:0]  block_size_counter;
reg  [15:0] block_count;
reg  [11:0] channel_control_reg;
reg         full_addr_enable;
reg         transfer_enable_bit;
reg         end_irq_enable;
reg         done;
reg  [1:0]  state;
reg  [1:0]  next_state;
reg         ext_prev;
reg         edge_pend;
reg  [6:0]  irq_prev;
reg  [6:0]  irq_pend;
reg         req_sel;

wire [6:0]  irq_in;
wire [3:0]  src_sel;
wire [1:0]  mode;
wire        legal;
wire        accept;
wire        fall;
wire        xfer_done;
wire        block_last;
wire        done_set;

// Mode from the two enable bits
function [1:0] mode_of;
    input fae;
    input block_enable;
    begin
        if (!fae)
            mode_of = `MODE_SHORT;
        else if (block_enable)
            mode_of = `MODE_BLOCK;
        else
            mode_of = `MODE_NORMAL;
    end
endfunction

// Source allowed for this mode and channel
function src_legal;
    input [1:0] md;
    input       chb;
    input [3:0] sel;
    reg         intl;
    reg         ext;
    reg         auto;
    begin
        intl = (sel <= `SRC_LAST_IRQ);
        ext  = (sel == `SRC_EXT_EDGE) || (sel == `SRC_EXT_LVL);
        auto = (sel == `SRC_AUTO);
        case (md)
            `MODE_SHORT:  src_legal = intl | (ext & chb);
            `MODE_NORMAL: src_legal = ext | auto;
            `MODE_BLOCK:  src_legal = intl | ext;
            default:      src_legal = 1'b0;
        endcase
    end
endfunction

// Address step after one unit
function [23:0] step_addr;
    input [23:0] a;
    input        en;
    input        down;
    input        word;
    reg   [23:0] unit;
    begin
        unit = word ? 24'h000002 : 24'h000001;
        if (!en)
            step_addr = a;
        else if (down)
            step_addr = a - unit;
        else
            step_addr = a + unit;
    end
endfunction

// Undo a whole block of steps; a hold of zero means 256
function [23:0] restore_addr;
    input [23:0] a;
    input        en;
    input        down;
    input        word;
    input [7:0]  m;
    reg   [23:0] amt;
    begin
        amt = {15'h0000, (m == 8'h00), m};
        if (word)
            amt = {amt[22:0], 1'b0};
        if (!en)
            restore_addr = a;
        else if (down)
            restore_addr = a + amt;
        else
            restore_addr = a - amt;
    end
endfunction

// Internal request lines in source-code order
assign irq_in = {timer2_match_irq, timer1_match_irq, timer0_match_irq,
                 serial1_rx_irq, serial1_tx_irq,
                 serial0_rx_irq, serial0_tx_irq};
assign src_sel = channel_control_reg[`CCR_SEL_HI:`CCR_SEL_LO];
assign mode = mode_of(full_addr_enable, channel_control_reg[`CCR_BLOCK_ENABLE]);
assign legal = src_legal(mode, channel_control_reg[`CCR_CHB], src_sel);
// Falling edge of the active-low request pin
assign fall = ext_prev & ~ext_request_pin_n;

// Selected request line
always @*
begin
    if (src_sel <= `SRC_LAST_IRQ)
        req_sel = irq_pend[src_sel[2:0]];
    else if (src_sel == `SRC_EXT_EDGE)
        req_sel = edge_pend;
    else if (src_sel == `SRC_EXT_LVL)
        req_sel = ~ext_request_pin_n;
    else
        req_sel = 1'b0;
end

// Accept only when idle, enabled, in block mode
assign accept = (state == S_IDLE) & transfer_enable_bit
              & (mode == `MODE_BLOCK) & legal & req_sel;
// A unit ends when its write is acknowledged
assign xfer_done  = (state == S_WR) & mem_ready;
// A count of zero runs 65536 blocks
assign block_last = (block_count == 16'h0001);
assign done_set   = (state == S_END) & block_last;

// Request capture; set wins over the clear on accept, a disabled channel clears all
always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
    begin
        ext_prev  <= 1'b1;
        edge_pend <= 1'b0;
        irq_prev  <= 7'h00;
        irq_pend  <= 7'h00;
    end
    else
    begin
        ext_prev <= ext_request_pin_n;
        irq_prev <= irq_in;
        if (!transfer_enable_bit)
        begin
            edge_pend <= 1'b0;
            irq_pend  <= 7'h00;
        end
        else
        begin
            // Edge during a block stays pending; a second one is merged
            edge_pend <= fall | (edge_pend &
                         ~(accept && src_sel == `SRC_EXT_EDGE));
            irq_pend  <= (irq_in & ~irq_prev) | (irq_pend &
                         ~({7{accept}} & (7'h01 << src_sel[2:0])));
        end
    end
end

// Sequencer: a block runs to its end once started
always @*
begin
    case (state)
        S_IDLE:  next_state = accept ? S_RD : S_IDLE;
        S_RD:    next_state = mem_ready ? S_WR : S_RD;
        S_WR:
        begin
            if (!mem_ready)
                next_state = S_WR;
            else if (block_size_counter == 8'h01)
                next_state = S_END;
            else
                next_state = S_RD;
        end
        S_END:   next_state = S_IDLE;
        default: next_state = S_IDLE;
    endcase
end

always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
        state <= S_IDLE;
    else
        state <= next_state;
end

// Registers; a software write in the same cycle wins
always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
    begin
        source_address      <= `RST_ADDR;
        destination_address <= `RST_ADDR;
        block_size_hold     <= `RST_BYTE;
        block_size_counter  <= `RST_BYTE;
        block_count         <= `RST_BCNT;
        channel_control_reg <= `RST_CCR;
        full_addr_enable    <= 1'b0;
        transfer_enable_bit <= 1'b0;
        end_irq_enable      <= 1'b0;
        mem_wdata           <= 16'h0000;
        reg_rdata           <= 32'h00000000;
    end
    else
    begin
        if ((state == S_RD) && mem_ready)
            mem_wdata <= mem_rdata;
        if (xfer_done)
        begin
            source_address <= step_addr(source_address,
                channel_control_reg[`CCR_SSTEP],
                channel_control_reg[`CCR_SDOWN],
                channel_control_reg[`CCR_SIZE]);
            destination_address <= step_addr(destination_address,
                channel_control_reg[`CCR_DSTEP],
                channel_control_reg[`CCR_DDOWN],
                channel_control_reg[`CCR_SIZE]);
            block_size_counter <= block_size_counter - 8'h01;
        end
        if (state == S_END)
        begin
            block_size_counter <= block_size_hold;
            if (channel_control_reg[`CCR_BDIR])
                source_address <= restore_addr(source_address,
                    channel_control_reg[`CCR_SSTEP],
                    channel_control_reg[`CCR_SDOWN],
                    channel_control_reg[`CCR_SIZE], block_size_hold);
            else
                destination_address <= restore_addr(destination_address,
                    channel_control_reg[`CCR_DSTEP],
                    channel_control_reg[`CCR_DDOWN],
                    channel_control_reg[`CCR_SIZE], block_size_hold);
            block_count <= block_count - 16'h0001;
            if (block_last)
                transfer_enable_bit <= 1'b0;
        end
        // Software write last, so it wins over hardware
        if (reg_wr)
        begin
            case (reg_addr)
                `OFS_SRC:  source_address      <= reg_wdata[23:0];
                `OFS_DST:  destination_address <= reg_wdata[23:0];
                `OFS_SIZE:
                begin
                    block_size_counter <= reg_wdata[7:0];
                    block_size_hold    <= reg_wdata[15:8];
                end
                `OFS_BCNT: block_count <= reg_wdata[15:0];
                `OFS_CCR:  channel_control_reg <= reg_wdata[11:0];
                `OFS_BAND:
                begin
                    full_addr_enable    <= reg_wdata[`BAND_FAE];
                    transfer_enable_bit <= reg_wdata[`BAND_DTE];
                    end_irq_enable      <= reg_wdata[`BAND_END_IRQ_ENABLE];
                end
                default: ;
            endcase
        end
        // Read data stand one cycle, zero otherwise
        if (reg_rd)
        begin
            case (reg_addr)
                `OFS_SRC:  reg_rdata <= {8'h00, source_address};
                `OFS_DST:  reg_rdata <= {8'h00, destination_address};
                `OFS_SIZE: reg_rdata <= {16'h0000, block_size_hold,
                                         block_size_counter};
                `OFS_BCNT: reg_rdata <= {16'h0000, block_count};
                `OFS_CCR:  reg_rdata <= {20'h00000, channel_control_reg};
                `OFS_BAND: reg_rdata <= {29'h00000000, end_irq_enable,
                                         transfer_enable_bit,
                                         full_addr_enable};
                `OFS_STAT: reg_rdata <= {27'h0000000, mode, ~legal, done,
                                         bus_busy};
                default:   reg_rdata <= 32'h00000000;
            endcase
        end
        else
            reg_rdata <= 32'h00000000;
    end
end

// End flag: write one to clear, a new end wins
always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
        done <= 1'b0;
    else
        done <= done_set | (done & ~(reg_wr && reg_addr == `OFS_STAT &&
                                     reg_wdata[`STAT_DONE]));
end

// Level request while the end flag stands
assign transfer_end_irq = done & end_irq_enable;
assign bus_busy = (state != S_IDLE);
assign mem_req  = (state == S_RD) || (state == S_WR);
assign mem_we   = (state == S_WR);
assign mem_word = channel_control_reg[`CCR_SIZE];
// Read from the source, write to the destination
assign mem_addr = (state == S_WR) ? destination_address : source_address;

endmodule // dma_block_xfer

// file: tb/dma_block_checker_properties.sv
// Assertions on the ports of the block-transfer DMA
`timescale 1ns/10ps
module dma_block_checker
(
    // Clock and reset
    input wire        mclk,
    input wire        rstn,
    // Register port
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // Memory master
    input wire        mem_req,
    input wire        mem_we,
    input wire [23:0] mem_addr,
    input wire [15:0] mem_wdata,
    input wire [15:0] mem_rdata,
    input wire        mem_ready,
    input wire        bus_busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    property p_we_req;
        mem_we |-> mem_req;
    endproperty
    a_we_req: assert property (p_we_req)
        else $error("write state without request");
    property p_hold;
        mem_req && !mem_ready |=>
            mem_req && $stable(mem_addr) && $stable(mem_we);
    endproperty
    a_hold: assert property (p_hold)
        else $error("bus request dropped before ready");
    property p_wdata;
        mem_req && !mem_we && mem_ready |=>
            mem_we && mem_wdata == $past(mem_rdata);
    endproperty
    a_wdata: assert property (p_wdata)
        else $error("read data not carried to write");
    property p_unit;
        mem_we && mem_ready |=> !mem_we;
    endproperty
    a_unit: assert property (p_unit)
        else $error("second write in one unit");
    property p_end;
        bus_busy && !mem_req |=> !bus_busy;
    endproperty
    a_end: assert property (p_end)
        else $error("bus held after end cycle");
    property p_start;
        $rose(bus_busy) |-> mem_req && !mem_we;
    endproperty
    a_start: assert property (p_start)
        else $error("block does not start with a read");
    property p_quiet;
        !bus_busy |-> !mem_req;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("bus request while idle");
    property p_rdata;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data outside its cycle");
endmodule // dma_block_checker

bind dma_block_xfer dma_block_checker chk_u (.mclk(mclk), .rstn(rstn),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready), .bus_busy(bus_busy));

// file: tb/mem_partner.sv
// Memory model on the block's bus master port
`timescale 1ns/10ps
module mem_partner
(
    // Clock
    input  wire         mclk,
    // Bus from the block
    input  wire         mem_req,
    input  wire         mem_we,
    input  wire  [23:0] mem_addr,
    input  wire  [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic        mem_ready,
    // Wait states and write log
    input  wire  [1:0]  lat,
    output int          n_wr,
    output logic [23:0] last_a,
    output logic [15:0] last_d
);
    logic [1:0] cnt = 2'h0;
    initial n_wr = 0;
    assign mem_ready = mem_req && cnt == lat;
    // Data only in an acked read, else its inverse
    assign mem_rdata = (mem_ready && !mem_we) ?
        mem_addr[15:0] ^ 16'hA5A5 : ~(mem_addr[15:0] ^ 16'hA5A5);
    always @(posedge mclk)
    begin
        cnt <= (mem_req && !mem_ready) ? cnt + 2'h1 : 2'h0;
        if (mem_req && mem_we && mem_ready)
        begin
            n_wr   <= n_wr + 1;
            last_a <= mem_addr;
            last_d <= mem_wdata;
        end
    end
endmodule // mem_partner

// file: tb/tb_dma_block_xfer.sv
// Self-checking bench for the block-transfer DMA
`timescale 1ns/10ps
`include "dma_block_regs.vh"
module tb_dma_block_xfer;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [6:0]  irq = 7'h00;
    logic        pin_n = 1'b1;
    logic [1:0]  lat = 2'h0;
    logic [31:0] reg_rdata;
    logic        mem_req, mem_we, mem_word, mem_ready, bus_busy, end_irq;
    logic [23:0] mem_addr, last_a;
    logic [15:0] mem_wdata, mem_rdata, last_d;
    int          n_wr, base, mismatches = 0, n_tests = 0, cyc = 0;
    logic [31:0] cfg [6] = '{32'h000, 32'h920, 32'h920, 32'h720, 32'h7A0,
                             32'h900};
    logic [31:0] bnd [6] = '{32'h7, 32'h7, 32'h6, 32'h6, 32'h6, 32'h7};
    logic [31:0] st [6] = '{32'h0C, 32'h14, 32'h04, 32'h04, 32'h00, 32'h08};
    always #2 mclk = ~mclk;
    dma_block_xfer dut_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .serial0_tx_irq(irq[0]),
        .serial0_rx_irq(irq[1]), .serial1_tx_irq(irq[2]),
        .serial1_rx_irq(irq[3]), .timer0_match_irq(irq[4]),
        .timer1_match_irq(irq[5]), .timer2_match_irq(irq[6]),
        .ext_request_pin_n(pin_n), .mem_req(mem_req), .mem_we(mem_we),
        .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ready(mem_ready),
        .bus_busy(bus_busy), .transfer_end_irq(end_irq));
    mem_partner mem_u (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ready(mem_ready), .lat(lat), .n_wr(n_wr), .last_a(last_a),
        .last_d(last_d));
    task automatic print_verdict;
        if (mismatches == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic setup(input logic [31:0] s, d, z, b, c, e);
        wr(`OFS_SRC, s);
        wr(`OFS_DST, d);
        wr(`OFS_SIZE, z);
        wr(`OFS_BCNT, b);
        wr(`OFS_CCR, c);
        wr(`OFS_BAND, e);
        base = n_wr;
    endtask
    // Pulse requests, then wait for the block to finish
    task automatic kick(input logic [6:0] v, input logic p);
        int k;
        k = 0;
        @(posedge mclk);
        irq   <= v;
        pin_n <= p;
        repeat (3) @(posedge mclk);
        irq   <= 7'h00;
        pin_n <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        while (bus_busy !== 1'b0 && k < 400)
        begin
            @(posedge mclk);
            #1;
            k++;
        end
        chk(bus_busy, 1'b0);
    endtask
    task automatic after_blk(input logic [31:0] s, d, z, b, n);
        rd(`OFS_SRC, s);
        rd(`OFS_DST, d);
        rd(`OFS_SIZE, z);
        rd(`OFS_BCNT, b);
        chk(n_wr - base, n);
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            print_verdict;
        end
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1;
        rd(`OFS_STAT, 32'h0);
        rd(8'h1C, 32'h0);
        // Falling edges, bytes, both up, destination area
        setup(32'h1000, 32'h2000, 32'h0303, 32'h2, 32'h72A, 32'h7);
        kick(7'h00, 1'b0);
        after_blk(32'h1003, 32'h2000, 32'h0303, 32'h1, 3);
        chk(last_a, 32'h2002);
        chk(last_d, 32'h1002 ^ 32'hA5A5);
        chk(mem_word, 1'b0);
        kick(7'h00, 1'b0);
        after_blk(32'h1006, 32'h2000, 32'h0303, 32'h0, 6);
        rd(`OFS_BAND, 32'h5);
        rd(`OFS_STAT, 32'h12);
        chk(end_irq, 1'b1);
        kick(7'h00, 1'b0);
        chk(n_wr - base, 6);
        wr(`OFS_STAT, 32'h2);
        rd(`OFS_STAT, 32'h10);
        chk(end_irq, 1'b0);
        // Every internal source: words, source down, destination fixed
        for (int c = 0; c < 7; c++)
        begin
            lat <= c[0] ? 2'h2 : 2'h0;
            setup(32'h100, 32'h200, 32'h0202, 32'h1, 32'h67 | (c << 8), 7);
            kick(7'h01 << c, 1'b1);
            after_blk(32'h100, 32'h200, 32'h0202, 32'h0, 2);
            chk(last_a, 32'h200);
            chk(last_d, 32'h00FE ^ 32'hA5A5);
            chk(mem_word, 1'b1);
        end
        // Low level keeps requesting until the count runs out
        wr(`OFS_STAT, 32'h2);
        setup(32'h3000, 32'h4000, 32'h0101, 32'h2, 32'h82A, 32'h3);
        @(posedge mclk);
        pin_n <= 1'b0;
        repeat (40) @(posedge mclk);
        kick(7'h00, 1'b1);
        after_blk(32'h3002, 32'h4000, 32'h0101, 32'h0, 2);
        rd(`OFS_STAT, 32'h12);
        chk(end_irq, 1'b0);
        wr(`OFS_STAT, 32'h2);
        // Sources refused or allowed by mode and channel
        for (int i = 0; i < 6; i++)
        begin
            setup(32'h0, 32'h0, 32'h0101, 32'h1, cfg[i], bnd[i]);
            kick(7'h7F, 1'b0);
            chk(n_wr - base, 0);
            rd(`OFS_STAT, st[i]);
        end
        print_verdict;
    end
endmodule // tb_dma_block_xfer
